// file: verilog/fcic_core.sv
// Instruction execution core of a 4-bit controller: fetch, decode,
// skip handling, RAM pointer, return stack, table lookup, timer loads.
// Assumes synchronous ROM and RAM: data stand in the cycle after the
// address; a RAM write is taken at the edge that ends the strobe cycle.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module fcic_core
    import fcic_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rstn,
    output logic     [PC_W-1:0]     romAddr,
    input  wire logic [INSTR_W-1:0] romData,
    output fcic_ram_req_t           ramReq,
    input  wire logic [3:0]         ramRdata,
    input  wire logic               extPinZero,
    input  wire logic               extPinOne,
    input  wire logic [1:0]         regAddr,
    input  wire logic [15:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic     [15:0]         regRdata,
    output fcic_timer_t             timers,
    output logic     [7:0]          extension
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    fcic_state_t       state_r;
    logic [PC_W-1:0]   pc_r;
    logic [PC_W-1:0]   pcNext;
    logic [PC_W-1:0]   pcInc;
    logic [9:0]        ir_r;
    logic [9:0]        xw_r;
    logic [3:0]        mem_r;
    logic [3:0]        acc_r;
    logic [3:0]        b_r;
    logic              carry_r;
    logic [3:0]        x_r;
    logic [3:0]        y_r;
    logic [1:0]        z_r;
    logic [3:0]        xNxt;
    logic [3:0]        yNxt;
    logic [1:0]        zNxt;
    logic [2:0]        dr_r;
    logic [7:0]        ext_r;
    logic              skip_r;
    logic              skipHit;
    fcic_ctrl_t        ctrl_r;
    logic [1:0]        exf_r;
    logic [1:0]        exfClr;
    logic [1:0]        pinSync;
    logic [1:0]        pinPrev_r;
    logic [1:0]        pinEvent;
    logic [1:0]        levelSel;
    fcic_op_t          op;
    fcic_op_t          opNow;
    logic              execNow;
    logic              xexecNow;
    logic              twoCycle;
    logic              oneWhenSkipped;
    logic              push;
    logic              pop;
    logic [PC_W-1:0]   stackTop;
    logic [SP_W-1:0]   stackIndex;
    logic [1:0]        bitSel;
    logic [3:0]        imm4;
    logic [HALF_W-1:0] addr7;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and return stack

    fcic_sync2 #(.W(2)) uPinSync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({extPinOne, extPinZero}),
        .q    (pinSync)
    );

    fcic_return_stack uStack (
        .clk      (clk),
        .rstn     (rstn),
        .push     (push),
        .pop      (pop),
        .pushData (pcInc),
        .top      (stackTop),
        .index    (stackIndex)
    );

    ////////////////////////////////////////////////////////////////////////
    // Decode

    assign op             = opOf(ir_r);
    assign opNow          = opOf(romData);
    assign execNow        = (state_r == ST_EXEC) && !skip_r;
    assign xexecNow       = (state_r == ST_XEXEC) && !skip_r;
    assign twoCycle       = op inside {OP_BL, OP_TABLE_LOOKUP_CALL, OP_RT, OP_RTS};
    assign oneWhenSkipped = op inside {OP_TABLE_LOOKUP_CALL, OP_RT, OP_RTS};
    assign bitSel         = ir_r[1:0];
    assign imm4           = ir_r[3:0];
    assign addr7          = ir_r[6:0];
    assign pcInc          = pc_r + 14'h0001;
    assign levelSel       = {ctrl_r.pin1LevelSelect, ctrl_r.pin0LevelSelect};

    // Calls push the address after the call; the index moves first
    assign push = execNow && (op inside {OP_BM, OP_TABLE_LOOKUP_CALL});
    assign pop  = xexecNow && (op inside {OP_TABLE_LOOKUP_CALL, OP_RT, OP_RTS});

    always_comb begin
        skipHit = 1'b0;
        if (execNow) begin
            unique case (op)
                OP_SZB:   skipHit = !mem_r[bitSel];
                OP_SKIP_ON_EXT0_REQUEST:  skipHit = !ctrl_r.ext0IrqEnableBit && exf_r[0];
                OP_SKIP_ON_EXT1_REQUEST:  skipHit = !ctrl_r.ext1IrqEnableBit && exf_r[1];
                OP_SKIP_ON_PIN0_LEVEL: skipHit = pinSync[0] == ctrl_r.pin0LevelSelect;
                OP_SKIP_ON_PIN1_LEVEL: skipHit = pinSync[1] == ctrl_r.pin1LevelSelect;
                default:  skipHit = 1'b0;
            endcase
        end
    end

    // A suppressed instruction only advances over its own words
    always_comb begin
        pcNext = pcInc;
        if (skip_r) begin
            pcNext = (op == OP_BL) ? pc_r + 14'h0002 : pcInc;
        end else begin
            unique case (op)
                OP_B:    pcNext = {pc_r[PC_W-1:HALF_W], addr7};
                OP_BL:   pcNext = {ir_r[6:0], xw_r[6:0]};
                OP_BM:   pcNext = {SHORT_CALL_PAGE, addr7};
                OP_TABLE_LOOKUP_CALL,
                OP_RT,
                OP_RTS:  pcNext = stackTop;
                default: pcNext = pcInc;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: each instruction cycle is fetch, decode, execute

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= ST_FETCH;
            pc_r    <= PC_RESET;
            romAddr <= PC_RESET;
            skip_r  <= 1'b0;
        end else begin
            unique case (state_r)
                ST_FETCH:   state_r <= ST_DECODE;
                ST_DECODE:  state_r <= ST_EXEC;
                ST_EXEC: begin
                    if (twoCycle && !(skip_r && oneWhenSkipped)) begin
                        state_r <= ST_XFETCH;
                        romAddr <= (op == OP_TABLE_LOOKUP_CALL && !skip_r) ? {1'b0, ir_r[5:0], dr_r, acc_r} : pcInc;
                    end else begin
                        state_r <= ST_FETCH;
                        pc_r    <= pcNext;
                        romAddr <= pcNext;
                        skip_r  <= skipHit;
                    end
                end
                ST_XFETCH:  state_r <= ST_XDECODE;
                ST_XDECODE: state_r <= ST_XEXEC;
                ST_XEXEC: begin
                    state_r <= ST_FETCH;
                    pc_r    <= pcNext;
                    romAddr <= pcNext;
                    skip_r  <= xexecNow && (op == OP_RTS);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ir_r  <= '0;
            xw_r  <= '0;
            mem_r <= '0;
        end else if (state_r == ST_DECODE) begin
            ir_r  <= romData;
            mem_r <= ramRdata;
        end else if (state_r == ST_XDECODE) begin
            xw_r  <= romData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, second register, carry, extension, table-high

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_r   <= '0;
            b_r     <= '0;
            carry_r <= 1'b0;
            ext_r   <= '0;
            dr_r    <= '0;
        end else if (execNow) begin
            unique case (op)
                OP_LA:   acc_r <= imm4;
                OP_TAM,
                OP_XAM:  acc_r <= mem_r;
                OP_TBA:  b_r <= acc_r;
                OP_TDA:  dr_r <= acc_r[2:0];
                OP_PAIR_TO_EXTENSION: ext_r <= {b_r, acc_r};
                OP_EXTENSION_TO_PAIR: {b_r, acc_r} <= ext_r;
                OP_STACK_INDEX_TO_ACC: acc_r <= {1'b0, stackIndex};
                OP_RAR: begin
                    acc_r   <= {carry_r, acc_r[3:1]};
                    carry_r <= acc_r[0];
                end
                default: acc_r <= acc_r;
            endcase
        end else if (xexecNow && op == OP_TABLE_LOOKUP_CALL) begin
            acc_r <= xw_r[3:0];
            b_r   <= xw_r[7:4];
            if (ctrl_r.tableUpperBitsFlag) begin
                dr_r <= {1'b0, xw_r[9:8]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // RAM pointer and RAM access

    always_comb begin
        xNxt = x_r;
        yNxt = y_r;
        zNxt = z_r;
        if (execNow) begin
            unique case (op)
                OP_LXY: begin
                    xNxt = ir_r[7:4];
                    yNxt = ir_r[3:0];
                end
                OP_LZ:   zNxt = ir_r[1:0];
                OP_TAM,
                OP_XAM,
                OP_TMA:  xNxt = x_r ^ imm4;
                default: xNxt = x_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_r <= '0;
            y_r <= '0;
            z_r <= '0;
        end else begin
            x_r <= xNxt;
            y_r <= yNxt;
            z_r <= zNxt;
        end
    end

    // Write strobe stands in the execute cycle at the unmodified pointer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ramReq <= '0;
        end else begin
            ramReq.addr <= {zNxt, xNxt, yNxt};
            ramReq.we   <= 1'b0;
            if (state_r == ST_DECODE && !skip_r) begin
                unique case (opNow)
                    OP_XAM,
                    OP_TMA: begin
                        ramReq.we    <= 1'b1;
                        ramReq.wdata <= acc_r;
                    end
                    OP_SB: begin
                        ramReq.we    <= 1'b1;
                        ramReq.wdata <= ramRdata | (4'h1 << romData[1:0]);
                    end
                    OP_RB: begin
                        ramReq.we    <= 1'b1;
                        ramReq.wdata <= ramRdata & ~(4'h1 << romData[1:0]);
                    end
                    default: ramReq.we <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // External request flags: set on the selected pin edge, set wins

    assign pinEvent = (levelSel & pinSync & ~pinPrev_r) | (~levelSel & ~pinSync & pinPrev_r);
    assign exfClr   = {skipHit && op == OP_SKIP_ON_EXT1_REQUEST, skipHit && op == OP_SKIP_ON_EXT0_REQUEST};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinPrev_r <= '0;
            exf_r     <= '0;
        end else begin
            pinPrev_r <= pinSync;
            exf_r     <= (exf_r & ~exfClr) | pinEvent;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer load registers

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timers <= '0;
        end else if (execNow) begin
            unique case (op)
                OP_TIMER1_LOAD_BOTH: begin
                    timers.timer1Reload <= {b_r, acc_r};
                    timers.timer1Count  <= {b_r, acc_r};
                end
                OP_TIMER1_LOAD_RELOAD_ONLY: timers.timer1Reload <= {b_r, acc_r};
                OP_T3AB: begin
                    timers.timer3ReloadLow <= {b_r, acc_r};
                    timers.timer3Count     <= {b_r, acc_r};
                end
                OP_TIMER3_COUNT_FROM_LOW_RELOAD: timers.timer3Count      <= timers.timer3ReloadLow;
                OP_TIMER3_HIGH_RELOAD_WRITE: timers.timer3ReloadHigh <= {b_r, acc_r};
                default:  timers <= timers;
            endcase
        end
    end

    assign extension = ext_r;

    ////////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RESET;
        end else if (regWr && regAddr == REG_CTRL) begin
            ctrl_r <= regWdata[4:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= '0;
        end else if (regRd) begin
            unique case (regAddr)
                REG_CTRL:   regRdata <= {11'h000, ctrl_r};
                REG_STATUS: regRdata <= {8'h00, exf_r, carry_r, skip_r, stackIndex, 1'b0};
                REG_PAIR:   regRdata <= {ext_r, b_r, acc_r};
                REG_PC:     regRdata <= {2'h0, pc_r};
            endcase
        end else begin
            regRdata <= '0;
        end
    end

endmodule

// file: verilog/fcic_pkg.sv
// Package for the 4-bit instruction core: opcodes, field positions,
// register offsets, reset values, states and carrier types.
// Assumes a 10-bit program ROM word and a 4-bit wide data RAM.
//
// Summary of operation
// - Met skip suppresses next instruction, keeps slot.
// - Skipped call/return-type instructions cost one cycle.
// - RAM pointer is bank, file, in-file address.
// - 14-bit counter, page and in-page halves.
// - Eight 14-bit return entries, 3-bit index.
// - Request flag test skips and clears unless enabled.
// - Pin test skips on level chosen by select.
// - Extension register loads from, and copies back to, second register, accumulator.
// - Stack index read gives zero in bit 3.
// - Memory moves XOR file register with immediate.
// - Short call pushes, jumps into page two.
// - Table lookup loads accumulator, second register, table-high.
// - Bit test skips on zero; set/clear touch one.
// - Timer 1 load both, or reload only.
// - Timer 3 count from low reload; high reload separate.
// - Rotate accumulator right through carry.
package fcic_pkg;

    localparam int PC_W    = 14;
    localparam int HALF_W  = 7;
    localparam int SP_W    = 3;
    localparam int DEPTH   = 8;
    localparam int DP_W    = 10;
    localparam int INSTR_W = 10;

    localparam logic [HALF_W-1:0]  SHORT_CALL_PAGE = 7'h02;
    localparam logic [PC_W-1:0]    PC_RESET        = 14'h0000;

    // Opcode classes, matched on the upper bits of the word; single opcodes on the whole word
    localparam logic [9:0] OPC_B     = 10'h180;
    localparam logic [9:0] OPC_BM    = 10'h100;
    localparam logic [9:0] OPC_BL    = 10'h080;
    localparam logic [9:0] OPC_TABLE_LOOKUP_CALL  = 10'h040;
    localparam logic [9:0] OPC_LXY   = 10'h300;
    localparam logic [9:0] OPC_LA    = 10'h200;
    localparam logic [9:0] OPC_TAM   = 10'h210;
    localparam logic [9:0] OPC_XAM   = 10'h220;
    localparam logic [9:0] OPC_TMA   = 10'h230;
    localparam logic [9:0] OPC_SB    = 10'h240;
    localparam logic [9:0] OPC_RB    = 10'h244;
    localparam logic [9:0] OPC_SZB   = 10'h248;
    localparam logic [9:0] OPC_LZ    = 10'h24c;
    localparam logic [9:0] OPC_PAIR_TO_EXTENSION  = 10'h001;
    localparam logic [9:0] OPC_EXTENSION_TO_PAIR  = 10'h002;
    localparam logic [9:0] OPC_STACK_INDEX_TO_ACC  = 10'h003;
    localparam logic [9:0] OPC_RT    = 10'h004;
    localparam logic [9:0] OPC_RTS   = 10'h005;
    localparam logic [9:0] OPC_SKIP_ON_EXT0_REQUEST  = 10'h006;
    localparam logic [9:0] OPC_SKIP_ON_EXT1_REQUEST  = 10'h007;
    localparam logic [9:0] OPC_SKIP_ON_PIN0_LEVEL = 10'h008;
    localparam logic [9:0] OPC_SKIP_ON_PIN1_LEVEL = 10'h009;
    localparam logic [9:0] OPC_TIMER1_LOAD_BOTH  = 10'h00a;
    localparam logic [9:0] OPC_TIMER1_LOAD_RELOAD_ONLY = 10'h00b;
    localparam logic [9:0] OPC_TIMER3_COUNT_FROM_LOW_RELOAD = 10'h00c;
    localparam logic [9:0] OPC_TIMER3_HIGH_RELOAD_WRITE = 10'h00d;
    localparam logic [9:0] OPC_RAR   = 10'h00e;
    localparam logic [9:0] OPC_TBA   = 10'h00f;
    localparam logic [9:0] OPC_T3AB  = 10'h010;
    localparam logic [9:0] OPC_TDA   = 10'h011;

    // Register port offsets and reset values
    localparam logic [1:0]  REG_CTRL   = 2'h0;
    localparam logic [1:0]  REG_STATUS = 2'h1;
    localparam logic [1:0]  REG_PAIR   = 2'h2;
    localparam logic [1:0]  REG_PC     = 2'h3;
    localparam logic [4:0]  CTRL_RESET = 5'h00;

    typedef enum logic [4:0] {
        OP_NOP, OP_B, OP_BM, OP_BL, OP_TABLE_LOOKUP_CALL, OP_LXY, OP_LA, OP_TAM, OP_XAM,
        OP_TMA, OP_SB, OP_RB, OP_SZB, OP_LZ, OP_PAIR_TO_EXTENSION, OP_EXTENSION_TO_PAIR, OP_STACK_INDEX_TO_ACC,
        OP_RT, OP_RTS, OP_SKIP_ON_EXT0_REQUEST, OP_SKIP_ON_EXT1_REQUEST, OP_SKIP_ON_PIN0_LEVEL, OP_SKIP_ON_PIN1_LEVEL, OP_TIMER1_LOAD_BOTH,
        OP_TIMER1_LOAD_RELOAD_ONLY, OP_TIMER3_COUNT_FROM_LOW_RELOAD, OP_TIMER3_HIGH_RELOAD_WRITE, OP_RAR, OP_TBA, OP_T3AB, OP_TDA
    } fcic_op_t;

    typedef enum {
        ST_FETCH, ST_DECODE, ST_EXEC, ST_XFETCH, ST_XDECODE, ST_XEXEC
    } fcic_state_t;

    typedef struct packed {
        logic       tableUpperBitsFlag;
        logic       pin1LevelSelect;
        logic       pin0LevelSelect;
        logic       ext1IrqEnableBit;
        logic       ext0IrqEnableBit;
    } fcic_ctrl_t;

    typedef struct packed {
        logic [DP_W-1:0] addr;
        logic [3:0]      wdata;
        logic            we;
    } fcic_ram_req_t;

    typedef struct packed {
        logic [7:0] timer1Reload;
        logic [7:0] timer1Count;
        logic [7:0] timer3ReloadLow;
        logic [7:0] timer3ReloadHigh;
        logic [7:0] timer3Count;
    } fcic_timer_t;

    function automatic fcic_op_t opOf(input logic [9:0] w);
        fcic_op_t o;
        o = OP_NOP;
        if (w[9:8] == OPC_LXY[9:8])           o = OP_LXY;
        else if (w[9:7] == OPC_B[9:7])        o = OP_B;
        else if (w[9:7] == OPC_BM[9:7])       o = OP_BM;
        else if (w[9:7] == OPC_BL[9:7])       o = OP_BL;
        else if (w[9:6] == OPC_TABLE_LOOKUP_CALL[9:6])     o = OP_TABLE_LOOKUP_CALL;
        else if (w[9:4] == OPC_LA[9:4])       o = OP_LA;
        else if (w[9:4] == OPC_TAM[9:4])      o = OP_TAM;
        else if (w[9:4] == OPC_XAM[9:4])      o = OP_XAM;
        else if (w[9:4] == OPC_TMA[9:4])      o = OP_TMA;
        else if (w[9:2] == OPC_SB[9:2])       o = OP_SB;
        else if (w[9:2] == OPC_RB[9:2])       o = OP_RB;
        else if (w[9:2] == OPC_SZB[9:2])      o = OP_SZB;
        else if (w[9:2] == OPC_LZ[9:2])       o = OP_LZ;
        else begin
            unique case (w)
                OPC_PAIR_TO_EXTENSION:  o = OP_PAIR_TO_EXTENSION;
                OPC_EXTENSION_TO_PAIR:  o = OP_EXTENSION_TO_PAIR;
                OPC_STACK_INDEX_TO_ACC:  o = OP_STACK_INDEX_TO_ACC;
                OPC_RT:    o = OP_RT;
                OPC_RTS:   o = OP_RTS;
                OPC_SKIP_ON_EXT0_REQUEST:  o = OP_SKIP_ON_EXT0_REQUEST;
                OPC_SKIP_ON_EXT1_REQUEST:  o = OP_SKIP_ON_EXT1_REQUEST;
                OPC_SKIP_ON_PIN0_LEVEL: o = OP_SKIP_ON_PIN0_LEVEL;
                OPC_SKIP_ON_PIN1_LEVEL: o = OP_SKIP_ON_PIN1_LEVEL;
                OPC_TIMER1_LOAD_BOTH:  o = OP_TIMER1_LOAD_BOTH;
                OPC_TIMER1_LOAD_RELOAD_ONLY: o = OP_TIMER1_LOAD_RELOAD_ONLY;
                OPC_TIMER3_COUNT_FROM_LOW_RELOAD: o = OP_TIMER3_COUNT_FROM_LOW_RELOAD;
                OPC_TIMER3_HIGH_RELOAD_WRITE: o = OP_TIMER3_HIGH_RELOAD_WRITE;
                OPC_RAR:   o = OP_RAR;
                OPC_TBA:   o = OP_TBA;
                OPC_T3AB:  o = OP_T3AB;
                OPC_TDA:   o = OP_TDA;
                default:   o = OP_NOP;
            endcase
        end
        return o;
    endfunction

endpackage

// file: verilog/fcic_sync2.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/100ps
module fcic_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// file: verilog/fcic_return_stack.sv
// Eight-entry return stack of program counter values with a 3-bit index.
// Assumes push and pop are never requested in the same cycle.
`timescale 1ns/100ps
module fcic_return_stack
    import fcic_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rstn,
    input  wire logic            push,
    input  wire logic            pop,
    input  wire logic [PC_W-1:0] pushData,
    output logic      [PC_W-1:0] top,
    output logic      [SP_W-1:0] index
);
    logic [PC_W-1:0] entry_r [DEPTH];
    logic [SP_W-1:0] indexInc;

    assign indexInc = index + 3'h1;
    assign top      = entry_r[index];

    // Index moves first on a push, last on a pop
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            index <= '0;
        end else if (push) begin
            index <= indexInc;
        end else if (pop) begin
            index <= index - 3'h1;
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                entry_r[i] <= '0;
            end else if (push && indexInc == SP_W'(i)) begin
                entry_r[i] <= pushData;
            end
        end
    end
endmodule

// file: verif/fcic_mem_model.sv
// Behavioural program ROM and data RAM beside the core.
// Assumes the core's synchronous timing: data one cycle after address.
`timescale 1ns/100ps
module fcic_mem_model
    import fcic_pkg::*;
(
    input  wire logic          clk,
    input  wire logic [PC_W-1:0] romAddr,
    output logic [INSTR_W-1:0] romData,
    input  wire fcic_ram_req_t ramReq,
    output logic [3:0]         ramRdata
);
    logic [9:0] rom [512];
    logic [3:0] ram [1024];
    initial begin
        foreach (rom[k]) rom[k] = 10'h000;
        foreach (ram[k]) ram[k] = 4'h0;
    end
    always_ff @(posedge clk) begin
        romData  <= rom[romAddr[8:0]];
        ramRdata <= ram[ramReq.addr];
        if (ramReq.we) begin
            ram[ramReq.addr] <= ramReq.wdata;
        end
    end
endmodule

// file: verif/fcic_core_properties.sv
// Port-level checks on the instruction core.
// Assumes one clock domain and reset of the core's ports.
`timescale 1ns/100ps
module fcic_core_properties
    import fcic_pkg::*;
(
    input wire logic          clk,
    input wire logic          rstn,
    input wire logic [PC_W-1:0] romAddr,
    input wire fcic_ram_req_t ramReq,
    input wire logic [1:0]    regAddr,
    input wire logic          regRd,
    input wire logic [15:0]   regRdata,
    input wire fcic_timer_t   timers,
    input wire logic [7:0]    extension
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    sequence holdTwo;
        $stable(romAddr) [*2];
    endsequence
    sequence pairRead;
        $past(regRd) && $past(regAddr) == REG_PAIR;
    endsequence
    chk_instr_slot: assert property ($changed(romAddr) |=> holdTwo)
        else $error("fetch slot shorter than three clocks");
    chk_we_single: assert property (ramReq.we |=> !ramReq.we)
        else $error("RAM write strobe longer than one cycle");
    chk_we_slot: assert property (ramReq.we |-> romAddr == $past(romAddr, 2))
        else $error("RAM write outside execute slot");
    chk_bank_held: assert property (ramReq.we |=> ramReq.addr[9:8] == $past(ramReq.addr[9:8]))
        else $error("bank bits changed by memory move");
    chk_pc_width: assert property ($past(regRd) && $past(regAddr) == REG_PC |-> regRdata[15:14] == 2'h0)
        else $error("counter wider than fourteen bits");
    chk_pair_ext: assert property (pairRead |-> regRdata[15:8] == $past(extension))
        else $error("pair read disagrees with extension");
    chk_t1_both: assert property ($changed(timers.timer1Count) |-> timers.timer1Count == timers.timer1Reload)
        else $error("timer 1 count loaded without reload");
    chk_t3_count: assert property ($changed(timers.timer3Count) |-> timers.timer3Count == timers.timer3ReloadLow)
        else $error("timer 3 count differs from low reload");
    chk_t3_high: assert property ($changed(timers.timer3ReloadHigh) |-> $stable(timers.timer3Count))
        else $error("high reload write touched timer 3 count");
endmodule
bind fcic_core fcic_core_properties i_fcic_core_properties (.clk(clk), .rstn(rstn), .romAddr(romAddr),
    .ramReq(ramReq), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .timers(timers),
    .extension(extension));

// file: verif/fcic_core_tb_top.sv
// Testbench: runs a short program from the ROM model, then checks state.
// Assumes the memory model and the bound checker.
`timescale 1ns/100ps
module fcic_core_tb_top
    import fcic_pkg::*;
;
    logic               clk, rstn, regWr, regRd;
    logic [1:0]         regAddr;
    logic [15:0]        regWdata, regRdata, rdv;
    logic [PC_W-1:0]    romAddr;
    logic [INSTR_W-1:0] romData;
    fcic_ram_req_t      ramReq;
    logic [3:0]         ramRdata;
    fcic_timer_t        timers;
    logic [7:0]         extension;
    int                 fail_count, samples_checked;
    // Ends in a jump to itself at 17; word 14 must be suppressed
    localparam logic [9:0] PROG [18] = '{10'h205, 10'h00f, 10'h20a, 10'h001, 10'h00a, 10'h203,
        10'h00b, 10'h010, 10'h201, 10'h00d, 10'h324, 10'h209, 10'h233, 10'h249, 10'h00f,
        10'h00e, 10'h110, 10'h191};
    fcic_core i_fcic_core (.clk(clk), .rstn(rstn), .romAddr(romAddr), .romData(romData),
        .ramReq(ramReq), .ramRdata(ramRdata), .extPinZero(1'b1), .extPinOne(1'b0),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .timers(timers), .extension(extension));
    fcic_mem_model i_fcic_mem_model (.clk(clk), .romAddr(romAddr), .romData(romData),
        .ramReq(ramReq), .ramRdata(ramRdata));
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        rstn = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 2'h0;
        regWdata = 16'h0000;
        fail_count = 0;
        samples_checked = 0;
        // Load after time zero so the model's own clearing cannot overwrite the program
        repeat (12) @(posedge clk);
        for (int k = 0; k < 18; k++) begin
            i_fcic_mem_model.rom[k] = PROG[k];
        end
        // Page two subroutine: stack index, rotate once through carry, return
        i_fcic_mem_model.rom[9'h110] = OPC_STACK_INDEX_TO_ACC;
        i_fcic_mem_model.rom[9'h111] = OPC_RAR;
        i_fcic_mem_model.rom[9'h112] = OPC_RT;
        rstn <= 1'b1;
        wr(REG_CTRL, 16'h0000);
        wr(REG_PAIR, 16'hffff);
        for (int n = 0; n < 500 && romAddr !== 14'h0011; n++) begin
            @(posedge clk);
        end
        repeat (12) @(posedge clk);
        chk("romAddr", 40'(romAddr), 40'h0011);
        rd(REG_PAIR, rdv);
        chk("pair", 40'(rdv), 40'h5a58);
        rd(REG_PC, rdv);
        chk("pc", 40'(rdv), 40'h0011);
        rd(REG_STATUS, rdv);
        chk("status", 40'(rdv), 40'h0020);
        chk("timers", timers, 40'h535a535153);
        chk("ramWord", 40'(i_fcic_mem_model.ram[10'h024]), 40'h9);
        chk("ramPtr", 40'(ramReq.addr), 40'h014);
        finish_test();
    end
endmodule
